// File: rtl/ssc_pkg.sv
// Purpose: Constants and carriers for the serial switch configuration bank
// Assumes: 50 MHz ref_clk
// Notes: All register offsets, fields and reset values live here
package ssc_pkg;
    localparam logic [3:0] ADDR_UPPER = 4'h9;
    localparam logic [7:0] OFF_FAST_CTL = 8'h00;
    localparam logic [7:0] OFF_SIDE_CTL = 8'h01;
    localparam logic [7:0] OFF_TERM_CTL = 8'h10;
    localparam logic [7:0] OFF_PULSE_LO = 8'h11;
    localparam logic [7:0] OFF_PULSE_HI = 8'h12;
    localparam logic [7:0] OFF_EQ_LO = 8'h13;
    localparam logic [7:0] OFF_EQ_HI = 8'h14;
    localparam logic [7:0] OFF_DRV_CTL = 8'h20;
    localparam logic [7:0] RST_FAST_CTL = 8'h40;
    localparam logic [7:0] RST_SIDE_CTL = 8'h40;
    localparam logic [7:0] RST_TERM_CTL = 8'h01;
    localparam logic [7:0] RST_PULSE = 8'h00;
    localparam logic [7:0] RST_EQ = 8'h00;
    localparam logic [7:0] RST_DRV_CTL = 8'h03;
    localparam int EN_BIT = 6;
    localparam int SEL_LSB = 0;
    localparam logic [7:0] MASK_PATH = 8'h43;
    localparam logic [7:0] MASK_TERM = 8'h01;
    localparam logic [7:0] MASK_DRV = 8'h0f;
    localparam int PE_LSB = 2;
    localparam int OTERM_BIT = 1;
    localparam int OCUR_BIT = 0;
    localparam int CLK_HZ = 50000000;
    localparam int PULSE_MS = 100;
    localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic fast_path_on;
        logic [1:0] fast_source_select;
        logic side_path_on;
        logic [1:0] side_source_select;
        logic input_term_on;
        logic [15:0] lane_term_connect;
        logic [15:0] equalizer_level_bits;
        logic [1:0] pre_emphasis_level;
        logic output_term_on;
        logic output_current_level;
    } ssc_ctrl_s;
endpackage : ssc_pkg

// File: rtl/ssc_i2c_slave.sv
// Purpose: Two-wire slave front end giving byte-level register accesses
// Assumes: Bus pins sampled on ref_clk, well oversampled
// Notes: Register pointer auto-increments after each data byte
module ssc_i2c_slave (
    input wire logic ref_clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic scl_in, // Serial clock level
    input wire logic sda_in, // Serial data level
    output logic sda_oe, // Pull data low while high
    input wire logic [2:0] addr_strap, // Low address bits
    output logic [7:0] reg_addr, // Register pointer
    output logic wr_stb, // Write pulse
    output logic [7:0] wr_data, // Write byte
    input wire logic [7:0] rd_data, // Read byte at pointer
    output logic bus_used // Pulse when addressed
);
    typedef enum logic [2:0] {IDLE, DEVADR, ACK, REGADR, WRDATA, RDDATA, RDACK} ssc_st_e;
    ssc_st_e st_reg;
    logic [1:0] scl_sync_reg, sda_sync_reg;
    logic scl_d_reg, sda_d_reg;
    logic [7:0] sh_reg;
    logic [3:0] cnt_reg;
    logic rd_reg, ptr_phase_reg;
    ssc_st_e after_ack_reg;
    logic scl_rise, scl_fall, start_c, stop_c;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_d_reg <= scl_sync_reg[1];
            sda_d_reg <= sda_sync_reg[1];
        end
    end

    assign scl_rise = scl_sync_reg[1] & ~scl_d_reg;
    assign scl_fall = ~scl_sync_reg[1] & scl_d_reg;
    assign start_c = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
    assign stop_c = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_reg <= IDLE;
            after_ack_reg <= IDLE;
            sh_reg <= 8'h00;
            cnt_reg <= 4'h0;
            rd_reg <= 1'b0;
            ptr_phase_reg <= 1'b0;
            reg_addr <= 8'h00;
            wr_stb <= 1'b0;
            wr_data <= 8'h00;
            sda_oe <= 1'b0;
            bus_used <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            bus_used <= 1'b0;
            if (start_c) begin
                st_reg <= DEVADR;
                cnt_reg <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                st_reg <= IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (st_reg)
                    DEVADR, REGADR, WRDATA: begin
                        if (scl_rise) begin
                            sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
                            cnt_reg <= cnt_reg + 4'h1;
                        end else if (scl_fall && cnt_reg == 4'h8) begin
                            cnt_reg <= 4'h0;
                            if (st_reg == DEVADR) begin
                                if (sh_reg[7:1] == {ssc_pkg::ADDR_UPPER, addr_strap}) begin
                                    sda_oe <= 1'b1;
                                    bus_used <= 1'b1;
                                    rd_reg <= sh_reg[0];
                                    after_ack_reg <= sh_reg[0] ? RDDATA : REGADR;
                                    st_reg <= ACK;
                                end else begin
                                    st_reg <= IDLE;
                                end
                            end else begin
                                sda_oe <= 1'b1;
                                st_reg <= ACK;
                                after_ack_reg <= WRDATA;
                                if (st_reg == REGADR) begin
                                    reg_addr <= sh_reg;
                                end else begin
                                    wr_data <= sh_reg;
                                    wr_stb <= 1'b1;
                                end
                            end
                        end
                    end
                    ACK: begin
                        if (scl_fall) begin
                            st_reg <= after_ack_reg;
                            if (st_reg == ACK && wr_data == sh_reg && after_ack_reg == WRDATA
                                && ptr_phase_reg) begin
                                reg_addr <= reg_addr + 8'h01;
                            end
                            ptr_phase_reg <= (after_ack_reg == WRDATA);
                            if (after_ack_reg == RDDATA) begin
                                sh_reg <= rd_data;
                                sda_oe <= ~rd_data[7];
                                cnt_reg <= 4'h1;
                            end else begin
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    RDDATA: begin
                        if (scl_fall) begin
                            if (cnt_reg == 4'h8) begin
                                sda_oe <= 1'b0;
                                st_reg <= RDACK;
                            end else begin
                                sda_oe <= ~sh_reg[7 - cnt_reg[2:0]];
                                cnt_reg <= cnt_reg + 4'h1;
                            end
                        end
                    end
                    RDACK: begin
                        if (scl_rise) begin
                            reg_addr <= reg_addr + 8'h01;
                            st_reg <= sda_sync_reg[1] ? IDLE : ACK;
                            after_ack_reg <= RDDATA;
                        end
                    end
                    default: st_reg <= IDLE;
                endcase
            end
        end
    end
endmodule : ssc_i2c_slave

// File: rtl/ssc_config_regs.sv
// Purpose: Serial configuration register bank of a four-to-one link switch
// Assumes: Bus pins and parallel pins synchronous to ref_clk
// Notes: Serial use locks out the parallel pins until reset
module ssc_config_regs #(
    parameter int PULSE_LEN = ssc_pkg::PULSE_CYCLES // Termination gap length in cycles
) (
    input wire logic ref_clk, // 50 MHz clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic scl_in, // Serial clock pin
    input wire logic sda_in, // Serial data pin level
    output logic sda_out, // Serial data drive value, always low
    output logic sda_oe, // Serial data drive enable
    input wire logic bus_addr_strap2, // Address strap bit 2
    input wire logic bus_addr_strap1, // Address strap bit 1
    input wire logic bus_addr_strap0, // Address strap bit 0
    input wire logic par_fast_on, // Parallel fast enable pin
    input wire logic [1:0] par_source_select, // Parallel source select pins
    input wire logic par_eq_high, // Parallel equalizer pin
    input wire logic [1:0] par_pre_emphasis, // Parallel emphasis pins
    input wire logic par_output_term, // Parallel output termination pin
    input wire logic par_output_current, // Parallel output current pin
    output logic serial_mode, // Serial control has taken over
    output ssc_pkg::ssc_ctrl_s ctrl // Decoded controls to analog circuits
);
    logic [7:0] fast_reg, side_reg, term_reg, pls_lo_reg, pls_hi_reg, eq_lo_reg, eq_hi_reg, drv_reg;
    logic [7:0] reg_addr, wr_data, rd_data;
    logic wr_stb, bus_used, sda_oe_w;
    logic [1:0] eff_sel_reg;
    logic [31:0] pulse_cnt_reg;
    logic pulsing;
    logic [1:0] eff_sel;
    ssc_pkg::ssc_ctrl_s ctrl_next;

    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] f, input logic [7:0] s,
        input logic [7:0] t, input logic [7:0] pl, input logic [7:0] ph, input logic [7:0] el,
        input logic [7:0] eh, input logic [7:0] d);
        case (a)
            ssc_pkg::OFF_FAST_CTL: reg_read = f;
            ssc_pkg::OFF_SIDE_CTL: reg_read = s;
            ssc_pkg::OFF_TERM_CTL: reg_read = t;
            ssc_pkg::OFF_PULSE_LO: reg_read = pl;
            ssc_pkg::OFF_PULSE_HI: reg_read = ph;
            ssc_pkg::OFF_EQ_LO: reg_read = el;
            ssc_pkg::OFF_EQ_HI: reg_read = eh;
            ssc_pkg::OFF_DRV_CTL: reg_read = d;
            default: reg_read = 8'h00;
        endcase
    endfunction : reg_read

    ssc_i2c_slave u_slave (
        .ref_clk(ref_clk),
        .reset(reset),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe(sda_oe_w),
        .addr_strap({bus_addr_strap2, bus_addr_strap1, bus_addr_strap0}),
        .reg_addr(reg_addr),
        .wr_stb(wr_stb),
        .wr_data(wr_data),
        .rd_data(rd_data),
        .bus_used(bus_used)
    );

    assign rd_data = reg_read(reg_addr, fast_reg, side_reg, term_reg, pls_lo_reg, pls_hi_reg,
        eq_lo_reg, eq_hi_reg, drv_reg);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe <= sda_oe_w;
        end
    end

    // Serial takeover latch
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            serial_mode <= 1'b0;
        end else if (bus_used) begin
            serial_mode <= 1'b1;
        end
    end

    // Register writes, reserved bits masked to zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fast_reg <= ssc_pkg::RST_FAST_CTL;
            side_reg <= ssc_pkg::RST_SIDE_CTL;
            term_reg <= ssc_pkg::RST_TERM_CTL;
            pls_lo_reg <= ssc_pkg::RST_PULSE;
            pls_hi_reg <= ssc_pkg::RST_PULSE;
            eq_lo_reg <= ssc_pkg::RST_EQ;
            eq_hi_reg <= ssc_pkg::RST_EQ;
            drv_reg <= ssc_pkg::RST_DRV_CTL;
        end else if (wr_stb) begin
            case (reg_addr)
                ssc_pkg::OFF_FAST_CTL: fast_reg <= wr_data & ssc_pkg::MASK_PATH;
                ssc_pkg::OFF_SIDE_CTL: side_reg <= wr_data & ssc_pkg::MASK_PATH;
                ssc_pkg::OFF_TERM_CTL: term_reg <= wr_data & ssc_pkg::MASK_TERM;
                ssc_pkg::OFF_PULSE_LO: pls_lo_reg <= wr_data;
                ssc_pkg::OFF_PULSE_HI: pls_hi_reg <= wr_data;
                ssc_pkg::OFF_EQ_LO: eq_lo_reg <= wr_data;
                ssc_pkg::OFF_EQ_HI: eq_hi_reg <= wr_data;
                ssc_pkg::OFF_DRV_CTL: drv_reg <= wr_data & ssc_pkg::MASK_DRV;
                default: fast_reg <= fast_reg;
            endcase
        end
    end

    assign eff_sel = serial_mode ? fast_reg[ssc_pkg::SEL_LSB +: 2] : par_source_select;

    // Termination gap timer, restarted on each fast path source change
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            eff_sel_reg <= 2'h0;
            pulse_cnt_reg <= 32'h0;
        end else begin
            eff_sel_reg <= eff_sel;
            if (eff_sel != eff_sel_reg) begin
                pulse_cnt_reg <= 32'(PULSE_LEN);
            end else if (pulse_cnt_reg != 32'h0) begin
                pulse_cnt_reg <= pulse_cnt_reg - 32'h1;
            end
        end
    end

    assign pulsing = (pulse_cnt_reg != 32'h0);

    always_comb begin
        ctrl_next = '0;
        if (serial_mode) begin
            ctrl_next.fast_path_on = fast_reg[ssc_pkg::EN_BIT];
            ctrl_next.fast_source_select = fast_reg[ssc_pkg::SEL_LSB +: 2];
            ctrl_next.side_path_on = side_reg[ssc_pkg::EN_BIT];
            ctrl_next.side_source_select = side_reg[ssc_pkg::SEL_LSB +: 2];
            ctrl_next.input_term_on = term_reg[0];
            ctrl_next.equalizer_level_bits = {eq_hi_reg, eq_lo_reg};
            ctrl_next.pre_emphasis_level = drv_reg[ssc_pkg::PE_LSB +: 2];
            ctrl_next.output_term_on = drv_reg[ssc_pkg::OTERM_BIT];
            ctrl_next.output_current_level = drv_reg[ssc_pkg::OCUR_BIT];
            ctrl_next.lane_term_connect = {16{term_reg[0]}} &
                ~({pls_hi_reg, pls_lo_reg} & {16{pulsing}});
        end else begin
            ctrl_next.fast_path_on = par_fast_on;
            ctrl_next.fast_source_select = par_source_select;
            ctrl_next.side_path_on = 1'b1;
            ctrl_next.side_source_select = par_source_select;
            ctrl_next.input_term_on = 1'b1;
            ctrl_next.equalizer_level_bits = {16{par_eq_high}};
            ctrl_next.pre_emphasis_level = par_pre_emphasis;
            ctrl_next.output_term_on = par_output_term;
            ctrl_next.output_current_level = par_output_current;
            ctrl_next.lane_term_connect = 16'hffff;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl <= '0;
        end else begin
            ctrl <= ctrl_next;
        end
    end
endmodule : ssc_config_regs

// File: tb/ssc_checker.sv
// Purpose: Port-level checks of the serial configuration bank
// Assumes: Bound to the top module
// Notes: Gap length handed on from the design parameter
module ssc_checker #(
    parameter int PULSE_LEN = 20 // Gap length in cycles
) (
    input wire logic ref_clk, // Clock
    input wire logic reset, // Sync reset
    input wire logic scl_in, // Bus clock
    input wire logic sda_in, // Bus data
    input wire logic sda_out, // Data drive value
    input wire logic sda_oe, // Data drive enable
    input wire logic bus_addr_strap2, // Strap 2
    input wire logic bus_addr_strap1, // Strap 1
    input wire logic bus_addr_strap0, // Strap 0
    input wire logic par_fast_on, // Pin enable
    input wire logic [1:0] par_source_select, // Pin select
    input wire logic par_eq_high, // Pin equalizer
    input wire logic [1:0] par_pre_emphasis, // Pin emphasis
    input wire logic par_output_term, // Pin termination
    input wire logic par_output_current, // Pin current
    input wire logic serial_mode, // Takeover flag
    input wire ssc_pkg::ssc_ctrl_s ctrl // Controls
);
    timeunit 1ns;
    timeprecision 1ps;
    int quiet_reg;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // Cycles since the routed source last moved
    always_ff @(posedge ref_clk) begin
        if (reset || $changed(ctrl.fast_source_select)) begin
            quiet_reg <= 0;
        end else if (quiet_reg < PULSE_LEN + 8) begin
            quiet_reg <= quiet_reg + 1;
        end
    end
    sticky_mode_a: assert property (serial_mode |=> serial_mode)
        else $error("serial mode dropped");
    par_fast_a: assert property (!serial_mode && !$past(reset) && !$past(reset, 2) |->
        ctrl.fast_path_on == $past(par_fast_on) && ctrl.fast_source_select == $past(par_source_select))
        else $error("fast path not from pins");
    par_rest_a: assert property (!serial_mode && !$past(reset) && !$past(reset, 2) |->
        ctrl.side_path_on && ctrl.input_term_on && ctrl.side_source_select == $past(par_source_select)
        && ctrl.equalizer_level_bits == {16{$past(par_eq_high)}} && ctrl.pre_emphasis_level == $past(par_pre_emphasis)
        && ctrl.output_term_on == $past(par_output_term) && ctrl.output_current_level == $past(par_output_current))
        else $error("controls not from pins");
    sda_low_a: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("data drive not low");
    oe_scl_low_a: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data pulled while clock high");
    oe_steady_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data moved while clock high");
    oe_match_a: assert property ($rose(sda_oe) |-> ##[0:4] serial_mode)
        else $error("answer without takeover");
    term_off_a: assert property (!ctrl.input_term_on |-> ctrl.lane_term_connect == 16'h0000)
        else $error("termination on while off");
    term_full_a: assert property (quiet_reg > PULSE_LEN + 4 && ctrl.input_term_on |->
        ctrl.lane_term_connect == 16'hffff)
        else $error("gap outlived its length");
    cover property ($rose(serial_mode));
    cover property ($rose(sda_oe));
    cover property (ctrl.input_term_on && ctrl.lane_term_connect != 16'hffff);
endmodule : ssc_checker

// File: tb/ssc_i2c_master.sv
// Purpose: Two-wire bus master standing in for the host
// Assumes: Data line has a pull-up; one bus quarter is 8 clocks
// Notes: Clock stands high between frames
module ssc_i2c_master (
    input wire logic ref_clk, // Bench clock
    input wire logic sda_oe, // Slave pulls data low
    output logic scl_in, // Bus clock level
    output logic sda_in // Resolved data level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sda_rel;
    initial begin
        scl_in = 1'b1;
        sda_rel = 1'b1;
    end
    assign sda_in = sda_rel & ~sda_oe;
    task automatic qtr();
        repeat (8) @(negedge ref_clk);
    endtask : qtr
    task automatic bit_cycle(input logic b, output logic got);
        sda_rel = b;
        qtr();
        scl_in = 1'b1;
        qtr();
        got = sda_in;
        qtr();
        scl_in = 1'b0;
        qtr();
    endtask : bit_cycle
    // Start when last is low, stop when last is high
    task automatic cond(input logic first, input logic last);
        sda_rel = first;
        qtr();
        scl_in = 1'b1;
        qtr();
        sda_rel = last;
        qtr();
        scl_in = last;
        qtr();
    endtask : cond
    task automatic xfer_byte(input logic [7:0] b, output logic [7:0] got, output logic acked);
        logic nak;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], got[i]);
        end
        bit_cycle(1'b1, nak);
        acked = ~nak;
    endtask : xfer_byte
    task automatic access(input logic [2:0] strap, input logic rd, input logic [7:0] ra, input logic [7:0] wd,
        output logic [7:0] rdat, output logic ok);
        logic [7:0] junk;
        logic a0, a1, a2, a3;
        cond(1'b1, 1'b0);
        xfer_byte({ssc_pkg::ADDR_UPPER, strap, 1'b0}, junk, a0);
        xfer_byte(ra, junk, a1);
        rdat = 8'h00;
        if (rd) begin
            cond(1'b1, 1'b0);
            xfer_byte({ssc_pkg::ADDR_UPPER, strap, 1'b1}, junk, a2);
            xfer_byte(8'hff, rdat, a3);
        end else begin
            xfer_byte(wd, junk, a2);
        end
        cond(1'b0, 1'b1);
        ok = a0 & a1 & a2;
    endtask : access
endmodule : ssc_i2c_master

// File: tb/tb.sv
// Purpose: Self-checking bench for the serial configuration bank
// Assumes: Master model speaks the two-wire bus
// Notes: Short gap parameter keeps the run brief
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAP = 200;
    localparam logic [7:0] OFFS [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
    localparam logic [7:0] DFLT [8] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
    localparam logic [7:0] WVAL [8] = '{8'hff, 8'hbe, 8'hfe, 8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'hf6};
    localparam logic [7:0] RVAL [8] = '{8'h43, 8'h02, 8'h00, 8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'h06};
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic scl_in, sda_in, sda_out, sda_oe, serial_mode, ok;
    logic [2:0] strap = 3'h5;
    logic par_fast_on = 1'b0;
    logic [1:0] par_source_select = 2'h2;
    logic par_eq_high = 1'b1;
    logic [1:0] par_pre_emphasis = 2'h1;
    logic par_output_term = 1'b0;
    logic par_output_current = 1'b1;
    logic [7:0] rd;
    ssc_pkg::ssc_ctrl_s ctrl;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    always #10 ref_clk = ~ref_clk;
    ssc_config_regs #(.PULSE_LEN(GAP)) ssc_config_regs_i (.ref_clk(ref_clk), .reset(reset), .scl_in(scl_in),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .bus_addr_strap2(strap[2]), .bus_addr_strap1(strap[1]),
        .bus_addr_strap0(strap[0]), .par_fast_on(par_fast_on), .par_source_select(par_source_select),
        .par_eq_high(par_eq_high), .par_pre_emphasis(par_pre_emphasis), .par_output_term(par_output_term),
        .par_output_current(par_output_current), .serial_mode(serial_mode), .ctrl(ctrl));
    ssc_i2c_master ssc_i2c_master_i (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));
    function automatic logic [15:0] knobs();
        return {5'h0, ctrl.fast_path_on, ctrl.fast_source_select, ctrl.side_path_on, ctrl.side_source_select,
            ctrl.input_term_on, ctrl.pre_emphasis_level, ctrl.output_term_on, ctrl.output_current_level};
    endfunction : knobs
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] ra, input logic [7:0] d);
        ssc_i2c_master_i.access(strap, 1'b0, ra, d, rd, ok);
        check({15'h0, ok}, 16'h0001);
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] ra, input logic [7:0] exp);
        ssc_i2c_master_i.access(strap, 1'b1, ra, 8'h00, rd, ok);
        check({7'h0, ok, rd}, {8'h01, exp});
    endtask : reg_rd
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            error_cnt++;
            $display("BAD %0t: run hung", $time);
            complete_run();
        end
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        repeat (3) @(negedge ref_clk);
        check(knobs(), {5'h0, 1'b0, 2'h2, 1'b1, 2'h2, 1'b1, 2'h1, 1'b0, 1'b1});
        for (int b = 0; b < 3; b++) begin
            ssc_i2c_master_i.access(strap ^ (3'h1 << b), 1'b0, 8'h00, 8'h00, rd, ok);
            check({15'h0, ok | serial_mode}, 16'h0000);
        end
        reg_rd(8'h00, 8'h40);
        check({15'h0, serial_mode}, 16'h0001);
        check(knobs(), {5'h0, 1'b1, 2'h0, 1'b1, 2'h0, 1'b1, 2'h0, 1'b1, 1'b1});
        check(ctrl.equalizer_level_bits, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            reg_rd(OFFS[i], DFLT[i]);
            reg_wr(OFFS[i], WVAL[i]);
            reg_rd(OFFS[i], RVAL[i]);
        end
        reg_wr(8'h15, 8'h77);
        reg_rd(8'h15, 8'h00);
        check(knobs(), {5'h0, 1'b1, 2'h3, 1'b0, 2'h2, 1'b0, 2'h1, 1'b1, 1'b0});
        check(ctrl.equalizer_level_bits, 16'hc35a);
        check(ctrl.lane_term_connect, 16'h0000);
        reg_wr(8'h10, 8'h01);
        check(ctrl.lane_term_connect, 16'hffff);
        for (int i = 0; i < 4; i++) begin
            reg_wr(8'h00, {1'b0, i[0], 4'h0, i[1:0]});
            check({13'h0, ctrl.fast_path_on, ctrl.fast_source_select}, {13'h0, i[0], i[1:0]});
            check(ctrl.lane_term_connect, 16'hc35a);
            repeat (GAP + 10) @(negedge ref_clk);
            check(ctrl.lane_term_connect, 16'hffff);
            reg_wr(8'h01, {1'b0, ~i[0], 4'h0, i[1:0]});
            check({13'h0, ctrl.side_path_on, ctrl.side_source_select}, {13'h0, ~i[0], i[1:0]});
        end
        reg_wr(8'h00, 8'h43);
        check(ctrl.lane_term_connect, 16'hffff);
        par_pre_emphasis = 2'h3;
        par_eq_high = 1'b0;
        repeat (4) @(negedge ref_clk);
        check({14'h0, ctrl.pre_emphasis_level}, 16'h0001);
        check(ctrl.equalizer_level_bits, 16'hc35a);
        reset = 1'b1;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        repeat (3) @(negedge ref_clk);
        check({15'h0, serial_mode}, 16'h0000);
        check(knobs(), {5'h0, 1'b0, 2'h2, 1'b1, 2'h2, 1'b1, 2'h3, 1'b0, 1'b1});
        reg_rd(8'h00, 8'h40);
        reg_rd(8'h20, 8'h03);
        complete_run();
    end
endmodule : tb
bind ssc_config_regs ssc_checker #(.PULSE_LEN(PULSE_LEN)) ssc_checker_i (.ref_clk(ref_clk), .reset(reset),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .bus_addr_strap2(bus_addr_strap2),
    .bus_addr_strap1(bus_addr_strap1), .bus_addr_strap0(bus_addr_strap0), .par_fast_on(par_fast_on),
    .par_source_select(par_source_select), .par_eq_high(par_eq_high), .par_pre_emphasis(par_pre_emphasis),
    .par_output_term(par_output_term), .par_output_current(par_output_current), .serial_mode(serial_mode),
    .ctrl(ctrl));
